// *** tlsc_pkg.sv ***
/*
   Constants and types shared by the low-speed control block of the
   transceiver module and its 2-wire slave engine.
   Assumes a 100 MHz core clock; all pin timing is expressed in cycles.
*/
package tlsc_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int         CLK_NS      = 10;
   // Shortest reset pulse that counts; shorter lows are glitches
   localparam int         RST_MIN_NS  = 1000;
   // Time spent re-initialising before the module reports ready
   localparam int         INIT_NS     = 2000;
   localparam logic [7:0] RST_MIN_CYC =
      8'((RST_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] INIT_CYC    =
      8'((INIT_NS + CLK_NS - 1) / CLK_NS);

   // ------------------------------------------------------------------
   // 2-wire slave address and map layout
   // ------------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR   = 7'h50;
   localparam logic [2:0] IDX_STATUS = 3'h0;
   localparam logic [2:0] IDX_FLAGS  = 3'h1;
   localparam logic [2:0] IDX_CTRL   = 3'h2;
   localparam int ST_INIT_BIT      = 0;
   localparam int ST_LP_BIT        = 1;
   localparam int ST_HP_BIT        = 2;
   localparam int FL_DONE_BIT      = 0;
   localparam int CTL_FORCE_LP_BIT = 0;
   localparam logic [7:0] STATUS_RST = 8'h01;
   localparam logic [7:0] FLAGS_RST  = 8'h00;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] MEM_RST    = 8'h00;
   localparam logic [7:0][7:0] MEM_DFLT =
      {{5{MEM_RST}}, CTRL_RST, FLAGS_RST, STATUS_RST};

   // ------------------------------------------------------------------
   // Pin synchroniser lanes
   // ------------------------------------------------------------------
   localparam int SY_SEL = 0;
   localparam int SY_RST = 1;
   localparam int SY_LP  = 2;
   localparam int SY_SCL = 3;
   localparam int SY_SDA = 4;
   localparam int SY_W   = 5;

   // ------------------------------------------------------------------
   // State encodings (Gray along the usual path)
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      RS_INIT = 2'h0,
      RS_RUN  = 2'h1,
      RS_HOLD = 2'h3,
      RS_REL  = 2'h2
   } tlsc_rst_t;

   typedef enum logic [1:0] {
      TW_IDLE = 2'h0,
      TW_ADDR = 2'h1,
      TW_XFER = 2'h3,
      TW_IGN  = 2'h2
   } tlsc_tw_t;

endpackage : tlsc_pkg

// *** tlsc_if.sv ***
/*
   Link between the control block and its 2-wire slave engine.
   Assumes both ends run on the same core clock.
*/
interface tlsc_if;
   logic       scl;
   logic       sda;
   logic       sel_n;
   logic       drv;
   logic       wr;
   logic       rdp;
   logic [2:0] ptr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport twi (input scl, sda, sel_n, rdata,
                output drv, wr, rdp, ptr, wdata);
   modport ctl (output scl, sda, sel_n, rdata,
                input drv, wr, rdp, ptr, wdata);
endinterface : tlsc_if

// *** tlsc_twi.sv ***
/*
   2-wire serial slave engine: start/stop detection, address match,
   pointer byte, sequential write and read of the 8-byte map.
   Assumes scl/sda/sel_n arrive already synchronised to clk.
*/
module tlsc_twi import tlsc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Toward the control block
   tlsc_if.twi      bus
);

   typedef struct packed {
      tlsc_tw_t   st;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic       rd;
      logic       have_ptr;
      logic       drv;
      logic       scl_d;
      logic       sda_d;
      logic       wr;
      logic       rdp;
      logic [2:0] ptr;
      logic [7:0] wdata;
   } tlsc_tw_st_t;

   localparam tlsc_tw_st_t Q_RST = '{st: TW_IDLE, scl_d: 1'b1,
      sda_d: 1'b1, default: '0};

   tlsc_tw_st_t q;
   tlsc_tw_st_t n;
   logic        rise;
   logic        fall;
   logic        start;
   logic        stop;

   // Bus conditions seen on the synchronised lines
   assign rise  = bus.scl & ~q.scl_d;
   assign fall  = ~bus.scl & q.scl_d;
   assign start = bus.scl & q.scl_d & q.sda_d & ~bus.sda;
   assign stop  = bus.scl & q.scl_d & ~q.sda_d & bus.sda;

   // Byte engine; data shifts on scl fall, samples on scl rise
   always_comb begin
      n       = q;
      n.scl_d = bus.scl;
      n.sda_d = bus.sda;
      n.wr    = 1'b0;
      n.rdp   = 1'b0;
      if (q.wr || q.rdp) begin
         n.ptr = q.ptr + 3'h1;
      end
      if (bus.sel_n) begin
         n.st  = TW_IDLE;
         n.drv = 1'b0;
      end else if (start) begin
         n.st  = TW_ADDR;
         // The scl fall that closes the start wraps this back to 0, so
         // that fall is not counted as a data bit
         n.cnt = 4'hf;
         n.drv = 1'b0;
         n.rd  = 1'b0;
      end else if (stop) begin
         n.st  = TW_IDLE;
         n.drv = 1'b0;
      end else if (q.st == TW_ADDR || q.st == TW_XFER) begin
         if (rise) begin
            if (q.cnt < 4'h8 && !(q.st == TW_XFER && q.rd)) begin
               n.sh = {q.sh[6:0], bus.sda};
            end else if (q.cnt == 4'h8 && q.st == TW_XFER && q.rd &&
                         bus.sda) begin
               n.st = TW_IGN;                   // Master ended the read
            end
         end else if (fall) begin
            n.cnt = q.cnt + 4'h1;
            if (q.cnt == 4'h7) begin
               if (q.st == TW_ADDR) begin
                  if (q.sh[7:1] == DEV_ADDR) begin
                     n.drv      = 1'b1;
                     n.rd       = q.sh[0];
                     n.have_ptr = 1'b0;
                  end else begin
                     n.st = TW_IGN;
                  end
               end else if (q.rd) begin
                  n.drv = 1'b0;                 // Leave ack slot to master
               end else begin
                  n.drv = 1'b1;
                  if (!q.have_ptr) begin
                     n.ptr      = q.sh[2:0];
                     n.have_ptr = 1'b1;
                  end else begin
                     n.wr    = 1'b1;
                     n.wdata = q.sh;
                  end
               end
            end else if (q.cnt == 4'h8) begin
               n.cnt = 4'h0;
               n.drv = 1'b0;
               if (q.st == TW_ADDR) begin
                  n.st = TW_XFER;
               end
               if (q.rd) begin
                  n.sh  = bus.rdata;
                  n.drv = ~bus.rdata[7];
                  n.rdp = 1'b1;
               end
            end else if (q.st == TW_XFER && q.rd) begin
               n.sh  = {q.sh[6:0], 1'b0};
               n.drv = ~q.sh[6];
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= Q_RST;
      end else begin
         q <= n;
      end
   end

   assign bus.drv   = q.drv;
   assign bus.wr    = q.wr;
   assign bus.rdp   = q.rdp;
   assign bus.ptr   = q.ptr;
   assign bus.wdata = q.wdata;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   chk_unsel_quiet: assert property (
      bus.sel_n |=> !q.drv && q.st == TW_IDLE)
      else $error("slave active while deselected");

   chk_foreign_addr: assert property (
      (fall && !bus.sel_n && q.st == TW_ADDR && q.cnt == 4'h7 &&
       q.sh[7:1] != DEV_ADDR) |=> q.st == TW_IGN && !q.drv)
      else $error("foreign address acknowledged");

   cov_write: cover property (q.wr);

endmodule : tlsc_twi

// *** tlsc_top.sv ***
/*
   Low-speed control of a pluggable four-lane transceiver module:
   pin synchronisers, reset pulse filter and re-init sequence, small
   management map reached by the host over 2-wire and by local logic
   over a plain register port, power cap, presence and interrupt pins.
   Assumes host pins are asynchronous and open-drain lines are resolved
   outside from the output enables.
*/
// Chosen here: the strobed register port and the address map.

module tlsc_top import tlsc_pkg::*; (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   // Host control inputs
   input  wire logic       MODULE_SELECT_N,
   input  wire logic       MODULE_RESET_N,
   input  wire logic       LOW_POWER_SELECT,
   // 2-wire serial pins
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_N,
   // Presence and interrupt pins
   output logic            MODULE_PRESENT_N,
   output logic            INT_OUT,
   output logic            INT_OE_N,
   // Power class toward the optics
   output logic            POWER_LIMIT,
   // Local register port
   input  wire logic [2:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   output logic      [7:0] REG_RDATA
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [SY_W-1:0] s1;
      logic [SY_W-1:0] s2;
      tlsc_rst_t       st;
      logic [7:0]      rst_cnt;
      logic [7:0]      init_cnt;
      logic [7:0][7:0] mem;
      logic [7:0]      rdata;
      logic            sda_oe_n;
      logic            int_oe_n;
      logic            power_lim;
      logic            gnd;
   } tlsc_top_st_t;

   // Power-up lands in init so the ready interrupt follows unaided
   localparam tlsc_top_st_t Q_RST = '{
      s1:        '1,
      s2:        '1,
      st:        RS_INIT,
      rst_cnt:   8'h00,
      init_cnt:  8'h00,
      mem:       MEM_DFLT,
      rdata:     8'h00,
      sda_oe_n:  1'b1,
      int_oe_n:  1'b1,
      power_lim: 1'b1,
      gnd:       1'b0
   };

   tlsc_top_st_t q;
   tlsc_top_st_t n;

   tlsc_if bus ();

   // Map bytes the outside may overwrite directly
   function automatic logic tlsc_wable(input logic [2:0] idx);
      return idx >= IDX_CTRL;
   endfunction : tlsc_wable

   // ------------------------------------------------------------------
   // 2-wire slave engine
   // ------------------------------------------------------------------
   tlsc_twi u_twi (
      .clk (CLK),
      .rst (SYS_RST),
      .bus (bus.twi)
   );

   // Engine sees only synchronised pins
   assign bus.scl   = q.s2[SY_SCL];
   assign bus.sda   = q.s2[SY_SDA];
   assign bus.sel_n = q.s2[SY_SEL];
   assign bus.rdata = q.mem[bus.ptr];

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      n = q;

      // Two-stage synchronisers; only s2 feeds logic
      n.s1 = {SDA_IN, SCL_IN, LOW_POWER_SELECT,
              MODULE_RESET_N, MODULE_SELECT_N};
      n.s2 = q.s1;

      // Reading the flags over 2-wire clears them
      if (bus.rdp && bus.ptr == IDX_FLAGS) begin
         n.mem[IDX_FLAGS] = FLAGS_RST;
      end

      // Host writes win over a local write to the same byte
      if (bus.wr && tlsc_wable(bus.ptr)) begin
         n.mem[bus.ptr] = bus.wdata;
      end

      // Local writes to the flags byte only ever set bits
      if (REG_WR) begin
         if (REG_ADDR == IDX_FLAGS) begin
            n.mem[IDX_FLAGS] = n.mem[IDX_FLAGS] | REG_WDATA;
         end else if (tlsc_wable(REG_ADDR) &&
                      !(bus.wr && bus.ptr == REG_ADDR)) begin
            n.mem[REG_ADDR] = REG_WDATA;
         end
      end

      // Read data stand for the single cycle after the strobe
      n.rdata = REG_RD ? q.mem[REG_ADDR] : 8'h00;

      // Reset sequencer; later assignments override the writes above
      case (q.st)
         RS_RUN: begin
            if (q.s2[SY_RST]) begin
               n.rst_cnt = 8'h00;
            end else begin
               n.rst_cnt = q.rst_cnt + 8'h01;
               if (q.rst_cnt == RST_MIN_CYC - 8'h01) begin
                  n.st = RS_HOLD;
               end
            end
         end
         RS_HOLD: begin
            if (q.s2[SY_RST]) begin
               n.st = RS_REL;
            end
         end
         RS_REL: begin
            n.st       = RS_INIT;
            n.rst_cnt  = 8'h00;
            n.init_cnt = 8'h00;
            n.mem      = MEM_DFLT;
         end
         RS_INIT: begin
            // Reset pin is not watched here; init always runs out
            n.init_cnt = q.init_cnt + 8'h01;
            if (q.init_cnt == INIT_CYC - 8'h01) begin
               n.st                          = RS_RUN;
               n.mem[IDX_FLAGS][FL_DONE_BIT] = 1'b1;
            end
         end
         default: begin
            n.st = RS_INIT;
         end
      endcase

      // Pin high or software force selects the low-power class
      n.power_lim = q.s2[SY_LP] |
                    q.mem[IDX_CTRL][CTL_FORCE_LP_BIT];

      // Status byte is pure hardware state
      n.mem[IDX_STATUS]              = STATUS_RST;
      n.mem[IDX_STATUS][ST_INIT_BIT] = n.st != RS_RUN;
      n.mem[IDX_STATUS][ST_LP_BIT]   = n.power_lim;
      n.mem[IDX_STATUS][ST_HP_BIT]   = ~n.power_lim;

      // Interrupt held off until init is over, then any flag pulls low
      n.int_oe_n = ~(n.st == RS_RUN && |n.mem[IDX_FLAGS]);

      n.sda_oe_n = ~bus.drv;
      n.gnd      = 1'b0;
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         q <= Q_RST;
      end else begin
         q <= n;
      end
   end

   // Open-drain pins only ever drive low
   assign SDA_OUT          = q.gnd;
   assign SDA_OE_N         = q.sda_oe_n;
   assign MODULE_PRESENT_N = q.gnd;
   assign INT_OUT          = q.gnd;
   assign INT_OE_N         = q.int_oe_n;
   assign POWER_LIMIT      = q.power_lim;
   assign REG_RDATA        = q.rdata;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   chk_min_pulse: assert property (
      $rose(q.st == RS_HOLD) |-> q.rst_cnt == RST_MIN_CYC)
      else $error("reset accepted before minimum pulse");

   chk_short_glitch: assert property (
      (q.st == RS_RUN && q.s2[SY_RST]) ##1 !q.s2[SY_RST] [*8]
      ##1 q.s2[SY_RST] |-> q.st == RS_RUN)
      else $error("short reset glitch was taken");

   chk_defaults: assert property (
      q.st == RS_REL |=> q.mem[IDX_CTRL] == CTRL_RST &&
      q.mem[7] == MEM_RST && q.mem[IDX_STATUS][ST_INIT_BIT])
      else $error("defaults not restored after reset");

   chk_ready_irq: assert property (
      $rose(q.st == RS_RUN) |-> !INT_OE_N &&
      q.mem[IDX_FLAGS][FL_DONE_BIT] && !q.mem[IDX_STATUS][ST_INIT_BIT])
      else $error("ready not posted at end of reset");

   chk_init_time: assert property (
      (q.st == RS_INIT && q.init_cnt == 8'h00) |->
      ##200 q.st == RS_RUN)
      else $error("init did not finish on time");

   chk_lp_cap: assert property (
      q.s2[SY_LP] |=> POWER_LIMIT && !q.mem[IDX_STATUS][ST_HP_BIT])
      else $error("power not capped in low-power mode");

   chk_present: assert property (
      !MODULE_PRESENT_N)
      else $error("present line not held low");

   chk_int_cause: assert property (
      !INT_OE_N |-> q.st == RS_RUN && q.mem[IDX_FLAGS] != 8'h00)
      else $error("interrupt without a flag");

   chk_host_write: assert property (
      (bus.wr && bus.ptr == IDX_CTRL && q.st == RS_RUN) |=>
      q.mem[IDX_CTRL] == $past(bus.wdata))
      else $error("host write not stored");

   cov_pin_reset: cover property ($rose(q.st == RS_HOLD));
   cov_ready:     cover property ($rose(q.st == RS_RUN));
   cov_flag_read: cover property (bus.rdp && bus.ptr == IDX_FLAGS);
   cov_lp:        cover property ($rose(POWER_LIMIT));

endmodule : tlsc_top

// *** tlsc_host.sv ***
/*
   Host board model: 2-wire bus master with a pulled-up data line.
   Assumes the module pulls SDA through an active-low enable and that
   the bench drives module select itself; SCL idles high between frames.
*/
module tlsc_host (
   // Bus lines toward the module
   output logic      scl,
   output logic      sda,
   // Module's open-drain data driver
   input  wire logic dev_oe_n,
   input  wire logic dev_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------------
   // Wire and timing
   // ------------------------------------------------------------------
   // Quarter of the 125 ns bit time
   localparam realtime Q = 31.25;
   logic host_low;

   // Wired-AND with pull-up: a released line reads high, never stale
   assign sda = !(host_low || (!dev_oe_n && !dev_out));

   // Idle bus: clock parked high, data released
   initial begin
      scl = 1'b1;
      host_low = 1'b0;
   end

   // ------------------------------------------------------------------
   // Bus conditions and bits
   // ------------------------------------------------------------------
   // Start or repeated start; data falls while clock is high
   task automatic start();
      #Q;
      host_low = 1'b0;
      #Q;
      scl = 1'b1;
      #Q;
      host_low = 1'b1;
      #Q;
      scl = 1'b0;
   endtask : start

   // Stop; data rises while clock is high, clock then stands still
   task automatic stop();
      #Q;
      host_low = 1'b1;
      #Q;
      scl = 1'b1;
      #Q;
      host_low = 1'b0;
      #Q;
   endtask : stop

   // Data moves a quarter after the fall, so no false start or stop
   task automatic bit_io(input logic b, output logic rb);
      #Q;
      host_low = !b;
      #Q;
      scl = 1'b1;
      #Q;
      rb = sda;
      #Q;
      scl = 1'b0;
   endtask : bit_io

   // One byte out, MSB first, then the module's answer bit
   task automatic send(input logic [7:0] d, output logic ack);
      logic rb;
      for (int i = 7; i >= 0; i--) bit_io(d[i], rb);
      bit_io(1'b1, ack);
   endtask : send

   // One byte in; a NACK on the last byte ends the read
   task automatic recv(input logic last, output logic [7:0] d);
      logic rb;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, rb);
   endtask : recv

endmodule : tlsc_host

// *** tlsc_top_tb.sv ***
/*
   Self-checking bench of the low-speed control block.
   Assumes the host model above and the package constants.
*/
module tlsc_top_tb import tlsc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic       clk;
   logic       sys_rst;
   logic       sel_n;
   logic       rst_n;
   logic       lp_sel;
   logic       scl;
   logic       sda;
   logic       sda_out;
   logic       sda_oe_n;
   logic       present_n;
   logic       int_out;
   logic       int_oe_n;
   logic       pwr_lim;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   int         err_total;
   int         n_tests;
   int         cyc;

   tlsc_top u_dut (
      .CLK(clk), .SYS_RST(sys_rst), .MODULE_SELECT_N(sel_n),
      .MODULE_RESET_N(rst_n), .LOW_POWER_SELECT(lp_sel),
      .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
      .SDA_OE_N(sda_oe_n), .MODULE_PRESENT_N(present_n),
      .INT_OUT(int_out), .INT_OE_N(int_oe_n), .POWER_LIMIT(pwr_lim),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata)
   );

   tlsc_host u_host (
      .scl(scl), .sda(sda), .dev_oe_n(sda_oe_n), .dev_out(sda_out)
   );

   // 100 MHz core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, well above the expected run of a few thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         $display("[ERR] %0t run did not finish", $time);
         conclude();
      end
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Data stands one cycle after the strobe, then returns to zero
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge clk);
      #1;
      chk(reg_rdata, 8'h00, "read data not dropped");
   endtask : rd

   // Bounded wait for a level; pin 0 is the interrupt, 1 the power cap
   task automatic wait_pin(input bit pin, input logic v, input int lim,
                           input string what);
      int k;
      k = 0;
      while ((pin ? pwr_lim : int_oe_n) !== v && k < lim) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(pin ? pwr_lim : int_oe_n, v, what);
   endtask : wait_pin

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Power-up: idle pins, init pending, then the ready interrupt
   task automatic t_powerup();
      logic [7:0] d;
      chk({sda_oe_n, int_oe_n, pwr_lim}, 8'h07, "reset pins");
      chk(present_n, 1'b0, "presence");
      @(posedge clk);
      sys_rst <= 1'b0;
      rd(IDX_STATUS, d);
      chk(d[ST_INIT_BIT], 1'b1, "init pending");
      repeat (int'(INIT_CYC) - 30) @(posedge clk);
      chk(int_oe_n, 1'b1, "early ready");
      wait_pin(0, 1'b0, 60, "ready interrupt");
      rd(IDX_STATUS, d);
      chk(d[ST_INIT_BIT], 1'b0, "pending not cleared");
   endtask : t_powerup

   // Low-power pin and forced cap both limit power
   task automatic t_power();
      logic [7:0] d;
      @(posedge clk);
      lp_sel <= 1'b1;
      wait_pin(1, 1'b1, 8, "cap on pin");
      rd(IDX_STATUS, d);
      chk(d[ST_LP_BIT], 1'b1, "status cap");
      lp_sel <= 1'b0;
      wait_pin(1, 1'b0, 8, "cap off");
      wr(IDX_CTRL, 8'h01);
      wait_pin(1, 1'b1, 8, "forced cap");
   endtask : t_power

   // Write and read the map over 2-wire; read of flags clears them
   task automatic t_twi();
      logic       ack;
      logic [7:0] d0;
      logic [7:0] d1;
      wr(IDX_FLAGS, 8'h80);
      sel_n <= 1'b0;
      repeat (4) @(posedge clk);
      u_host.start();
      u_host.send({DEV_ADDR, 1'b0}, ack);
      chk(ack, 1'b0, "address ack");
      u_host.send({5'h00, IDX_CTRL}, ack);
      u_host.send(8'h5a, ack);
      u_host.send(8'hc3, ack);
      chk(ack, 1'b0, "data ack");
      u_host.stop();
      rd(3'h3, d0);
      chk(d0, 8'hc3, "2-wire write");
      rd(IDX_CTRL, d0);
      chk(d0, 8'h5a, "2-wire control write");
      u_host.start();
      u_host.send({DEV_ADDR, 1'b0}, ack);
      u_host.send({5'h00, IDX_CTRL}, ack);
      u_host.start();
      u_host.send({DEV_ADDR, 1'b1}, ack);
      u_host.recv(1'b0, d0);
      u_host.recv(1'b1, d1);
      u_host.stop();
      chk(d0, 8'h5a, "2-wire read 0");
      chk(d1, 8'hc3, "2-wire read 1");
      chk(int_oe_n, 1'b0, "interrupt held");
      u_host.start();
      u_host.send({DEV_ADDR, 1'b0}, ack);
      u_host.send({5'h00, IDX_FLAGS}, ack);
      u_host.start();
      u_host.send({DEV_ADDR, 1'b1}, ack);
      u_host.recv(1'b1, d0);
      u_host.stop();
      chk(d0, 8'h81, "flags cause");
      wait_pin(0, 1'b1, 10, "interrupt release");
      u_host.start();
      u_host.send({DEV_ADDR ^ 7'h02, 1'b0}, ack);
      u_host.stop();
      chk(ack, 1'b1, "foreign address");
      @(posedge clk);
      sel_n <= 1'b1;
      repeat (4) @(posedge clk);
      u_host.start();
      u_host.send({DEV_ADDR, 1'b0}, ack);
      u_host.stop();
      chk(ack, 1'b1, "deselected ack");
   endtask : t_twi

   // Short reset low is ignored, long one restores defaults
   task automatic t_modrst();
      logic [7:0] d;
      wr(3'h6, 8'h77);
      wr(IDX_FLAGS, 8'h02);
      // Very short low first, then a longer one still under the minimum
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b0;
      repeat (50) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      rd(3'h6, d);
      chk(d, 8'h77, "glitch reset");
      chk(int_oe_n, 1'b0, "glitch interrupt");
      rst_n <= 1'b0;
      repeat (int'(RST_MIN_CYC) + 20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      rd(3'h6, d);
      chk(d, 8'h00, "scratch default");
      rd(IDX_STATUS, d);
      chk(d[ST_INIT_BIT], 1'b1, "pending again");
      chk(int_oe_n, 1'b1, "interrupt in init");
      wait_pin(0, 1'b0, int'(INIT_CYC) + 20, "reset done");
      rd(IDX_FLAGS, d);
      chk(d, 8'h01, "flags default");
      wait_pin(1, 1'b0, 8, "control default");
   endtask : t_modrst

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      err_total = 0;
      n_tests = 0;
      cyc = 0;
      sys_rst = 1'b1;
      sel_n = 1'b1;
      rst_n = 1'b1;
      lp_sel = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (8) @(posedge clk);
      t_powerup();
      t_power();
      wr(IDX_CTRL, 8'h00);
      t_twi();
      wr(IDX_CTRL, 8'h01);
      t_modrst();
      conclude();
   end

endmodule : tlsc_top_tb
